// ===== verilog/damlc_params.svh
`ifndef DAMLC_PARAMS_SVH
`define DAMLC_PARAMS_SVH
// Behaviour
// - retrace-control bit low holds both retrace outputs cleared; nothing else reset
// - word/byte bit low shifts counter up one, bit 15 or 13 feeds output 0
// - doubleword bit high forces a two-position shift over word/byte bit
// - doubleword: out0=counter12, out1=counter13, out2..15=counter0..13
// - word mode: wrap bit picks counter 15 (1) or 13 (0) for output 0
// - count-by-two high clocks address counter at character clock over two while count-by-four is low
// - retrace-select high clocks vertical counter at horizontal retrace over two
// - row-scan select low puts row scan bit 1 on output 14
// - compat bit low puts row scan bit 0 on output 13 during display
// - vertical counter equal to 10-bit target clears the line start address at row start
// - count-by-four high clocks address counter at character clock over four
`define DAMLC_IDX_MODE        8'h17
`define DAMLC_IDX_LINECMP     8'h18
`define DAMLC_MODE_RESET      8'h00
`define DAMLC_LINECMP_RESET   8'hFF
`define DAMLC_BIT_RETRACE_EN  7
`define DAMLC_BIT_BYTE_MODE   6
`define DAMLC_BIT_WRAP        5
`define DAMLC_BIT_CNT_BY2     3
`define DAMLC_BIT_HR_SEL      2
`define DAMLC_BIT_ROW_SEL     1
`define DAMLC_BIT_COMPAT      0
`define DAMLC_MODE_RSVD_MASK  8'hEF
`endif

// ===== verilog/damlc_pkg.sv
package damlc_pkg;
   typedef logic [15:0] damlc_addr_t;
   typedef logic [9:0]  damlc_line_t;
   typedef enum logic [1:0] {
      DAMLC_BYTE  = 2'b00,
      DAMLC_WORD  = 2'b01,
      DAMLC_DWORD = 2'b10
   } damlc_amode_e;
endpackage : damlc_pkg

// ===== verilog/damlc_div.sv
`timescale 1ns/1ps
// pulse divider: passes every Nth tick (1, 2 or 4)
module damlc_div (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       tick,
   input  wire logic [1:0] sel,
   output logic            tickOut
);
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;

   // count ticks; sel 0 = every tick, 1 = every second, 2 = every fourth
   always_comb begin
      cnt_nxt = cnt_r;
      tickOut = 1'b0;
      if (tick) begin
         cnt_nxt = cnt_r + 2'd1;
         unique case (sel)
            2'd0: tickOut = 1'b1;
            2'd1: tickOut = cnt_r[0];
            default: tickOut = (cnt_r == 2'd3);
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r <= 2'd0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule : damlc_div

// ===== verilog/display_address_mux_line_compare.sv
`timescale 1ns/1ps
`include "damlc_params.svh"
module damlc_top (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regIndex,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   input  wire logic        doublewordSel,
   input  wire logic        countBy4,
   input  wire logic        lineCmpBit8,
   input  wire logic        lineCmpBit9,
   input  wire logic        charClkTick,
   input  wire logic        horizontalRetracePulse,
   input  wire logic        frameStart,
   input  wire logic        rowStart,
   input  wire logic        displayActive,
   input  wire logic [4:0]  rowScan,
   input  wire logic [15:0] lineStartLoad,
   input  wire logic [15:0] rowOffset,
   input  wire logic        hRetraceIn,
   input  wire logic        vRetraceIn,
   output logic             hRetraceOut,
   output logic             vRetraceOut,
   output logic      [15:0] refreshMemoryAddressOut,
   output logic      [9:0]  vertCount,
   output logic             lineMatch
);
   // host-visible registers
   logic [7:0]  modeCtl_r;
   logic [7:0]  modeCtl_nxt;
   logic [7:0]  lineCmp_r;
   logic [7:0]  lineCmp_nxt;

   // refresh counters
   logic [15:0] addrCnt_r;
   logic [15:0] addrCnt_nxt;
   logic [15:0] lineStart_r;
   logic [15:0] lineStart_nxt;
   logic [9:0]  vCnt_r;
   logic [9:0]  vCnt_nxt;

   // output multiplexer and its holding register
   logic [15:0] outAddr_r;
   logic [15:0] outAddr_nxt;
   logic [15:0] outHold_nxt;
   logic [15:0] shifted;

   // clock-rate selection and split-line target
   logic        addrTick;
   logic        vertTick;
   logic [1:0]  addrDivSel;
   logic [9:0]  target;
   damlc_pkg::damlc_amode_e amode;

   // register file write; reserved bit 4 of mode control stays zero
   always_comb begin
      modeCtl_nxt = modeCtl_r;
      lineCmp_nxt = lineCmp_r;
      if (regWrite && regIndex == `DAMLC_IDX_MODE) begin
         modeCtl_nxt = regWrData & `DAMLC_MODE_RSVD_MASK;
      end
      if (regWrite && regIndex == `DAMLC_IDX_LINECMP) begin
         lineCmp_nxt = regWrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         modeCtl_r <= `DAMLC_MODE_RESET;
         lineCmp_r <= `DAMLC_LINECMP_RESET;
      end else if (ce) begin
         modeCtl_r <= modeCtl_nxt;
         lineCmp_r <= lineCmp_nxt;
      end
   end

   // readback is combinational so the index/data pair reads in one cycle
   always_comb begin
      unique case (regIndex)
         `DAMLC_IDX_MODE:    regRdData = modeCtl_r;
         `DAMLC_IDX_LINECMP: regRdData = lineCmp_r;
         default:            regRdData = 8'h00;
      endcase
   end

   // retrace gating only
   // the enable bit only masks the retrace outputs; counters and registers
   // keep running so software can toggle it without losing the raster
   always_comb begin
      hRetraceOut = 1'b0;
      vRetraceOut = 1'b0;
      if (modeCtl_r[`DAMLC_BIT_RETRACE_EN]) begin
         hRetraceOut = hRetraceIn;
         vRetraceOut = vRetraceIn;
      end
   end

   // address counter rate; count-by-four wins over two
   assign addrDivSel = countBy4 ? 2'd2 : (modeCtl_r[`DAMLC_BIT_CNT_BY2] ? 2'd1 : 2'd0);

   damlc_div u_addrDiv (
      .mclk    (mclk),
      .rst     (rst),
      .ce      (ce),
      .tick    (charClkTick),
      .sel     (addrDivSel),
      .tickOut (addrTick)
   );

   damlc_div u_vertDiv (
      .mclk    (mclk),
      .rst     (rst),
      .ce      (ce),
      .tick    (horizontalRetracePulse),
      .sel     ({1'b0, modeCtl_r[`DAMLC_BIT_HR_SEL]}),
      .tickOut (vertTick)
   );

   assign target    = {lineCmpBit9, lineCmpBit8, lineCmp_r};
   assign lineMatch = (vCnt_r == target);

   // counters; a match takes priority so the split region starts at address zero
   // frame start still wins over everything, so a target beyond the last line
   // simply never fires and the whole screen scrolls as one region
   // the clear is taken at the row start so a half-drawn row is never cut
   always_comb begin
      vCnt_nxt      = vCnt_r;
      lineStart_nxt = lineStart_r;
      addrCnt_nxt   = addrCnt_r;
      if (frameStart) begin
         vCnt_nxt      = 10'd0;
         lineStart_nxt = lineStartLoad;
         addrCnt_nxt   = lineStartLoad;
      end else begin
         if (vertTick) begin
            vCnt_nxt = vCnt_r + 10'd1;
         end
         if (rowStart) begin
            lineStart_nxt = lineStart_r + rowOffset;
            addrCnt_nxt   = lineStart_r + rowOffset;
         end else if (addrTick) begin
            addrCnt_nxt = addrCnt_r + 16'd1;
         end
         if (lineMatch && rowStart) begin
            lineStart_nxt = 16'h0000;
            addrCnt_nxt   = 16'h0000;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         vCnt_r      <= 10'd0;
         lineStart_r <= 16'h0000;
         addrCnt_r   <= 16'h0000;
      end else if (ce) begin
         vCnt_r      <= vCnt_nxt;
         lineStart_r <= lineStart_nxt;
         addrCnt_r   <= addrCnt_nxt;
      end
   end

   always_comb begin
      if (doublewordSel) begin
         amode = damlc_pkg::DAMLC_DWORD;
      end else if (modeCtl_r[`DAMLC_BIT_BYTE_MODE]) begin
         amode = damlc_pkg::DAMLC_BYTE;
      end else begin
         amode = damlc_pkg::DAMLC_WORD;
      end
   end

   // output multiplexer: shift, then row-scan substitution
   always_comb begin
      unique case (amode)
         damlc_pkg::DAMLC_BYTE:  shifted = addrCnt_r;
         damlc_pkg::DAMLC_WORD:  shifted = {addrCnt_r[14:0],
                                            modeCtl_r[`DAMLC_BIT_WRAP] ? addrCnt_r[15] : addrCnt_r[13]};
         damlc_pkg::DAMLC_DWORD: shifted = {addrCnt_r[13:0], addrCnt_r[13], addrCnt_r[12]};
         default:                shifted = addrCnt_r;
      endcase
      outAddr_nxt = shifted;
      if (!modeCtl_r[`DAMLC_BIT_ROW_SEL]) begin
         outAddr_nxt[14] = rowScan[1];
      end
      if (!modeCtl_r[`DAMLC_BIT_COMPAT] && displayActive) begin
         outAddr_nxt[13] = rowScan[0];
      end
   end

   // registered once per character clock
   // holding between ticks keeps the address steady for the whole memory cycle
   always_comb begin
      outHold_nxt = outAddr_r;
      if (charClkTick) begin
         outHold_nxt = outAddr_nxt;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         outAddr_r <= 16'h0000;
      end else if (ce) begin
         outAddr_r <= outHold_nxt;
      end
   end

   assign refreshMemoryAddressOut = outAddr_r;
   assign vertCount               = vCnt_r;
endmodule : damlc_top

// ===== sim/damlc_properties.sv
`timescale 1ns/1ps
// watches the top ports only; mode and target are seen through the readback port
module damlc_properties (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [7:0]  regIndex,
   input wire logic [7:0]  regRdData,
   input wire logic        lineCmpBit8,
   input wire logic        lineCmpBit9,
   input wire logic        charClkTick,
   input wire logic        horizontalRetracePulse,
   input wire logic        frameStart,
   input wire logic        rowStart,
   input wire logic [4:0]  rowScan,
   input wire logic        hRetraceIn,
   input wire logic        vRetraceIn,
   input wire logic        hRetraceOut,
   input wire logic        vRetraceOut,
   input wire logic [15:0] refreshMemoryAddressOut,
   input wire logic [9:0]  vertCount,
   input wire logic        lineMatch
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // retrace outputs follow the mode register gate
   a_hretrace_gate: assert property (regIndex == 8'h17 |-> hRetraceOut == (hRetraceIn & regRdData[7]))
      else $error("h retrace gate wrong");
   a_vretrace_gate: assert property (regIndex == 8'h17 |-> vRetraceOut == (vRetraceIn & regRdData[7]))
      else $error("v retrace gate wrong");
   // address only moves on a character tick
   a_addr_hold: assert property (!(ce && charClkTick) |=> $stable(refreshMemoryAddressOut))
      else $error("address moved without tick");
   a_match_comb: assert property (regIndex == 8'h18 |->
      lineMatch == (vertCount == {lineCmpBit9, lineCmpBit8, regRdData}))
      else $error("line match wrong");
   a_frame_zero: assert property (ce && frameStart |=> vertCount == 10'h000)
      else $error("vertical count not cleared");
   // vertical counter is clocked by the retrace pulse alone, one step at most
   a_vert_idle: assert property (!ce || !(horizontalRetracePulse || frameStart) |=> $stable(vertCount))
      else $error("vertical count moved");
   a_vert_step: assert property (ce && horizontalRetracePulse && !frameStart |=>
      vertCount - $past(vertCount) <= 10'h001)
      else $error("vertical count step wrong");
   a_split_clear: assert property (ce && rowStart && lineMatch && !frameStart ##1
      ce && charClkTick && !rowStart && !frameStart && rowScan == 5'h00 |=> refreshMemoryAddressOut == 16'h0000)
      else $error("split line did not clear address");
endmodule : damlc_properties

// ===== sim/damlc_mem_model.sv
`timescale 1ns/1ps
// display memory: fetches the registered refresh address the cycle after each tick
module damlc_mem_model (
   input  wire logic        mclk,
   input  wire logic        fetchEn,
   input  wire logic [15:0] addr,
   output logic      [15:0] lastFetch
);
   logic fetchEnD = 1'b0;
   always_ff @(posedge mclk) begin
      fetchEnD <= fetchEn;
      if (fetchEnD) lastFetch <= addr;
   end
endmodule : damlc_mem_model

// ===== sim/tb.sv
`timescale 1ns/1ps
// bench: drives the block, models the address mux and judges the run
module tb;
   logic        mclk = 0, rst = 1, ce = 1, wr = 0, dw = 0, by4 = 0, tk = 0, hp = 0, fs = 0, rs = 0;
   logic        act = 0, hi = 0, vi = 0, ho, vo, lm;
   logic [7:0]  idx = '0, wd = '0, rd, m;
   logic [4:0]  scan = '0;
   logic [15:0] ls = '0, ro = '0, ma, mf, v, e;
   logic [9:0]  vc;
   logic [7:0]  mx = 8'h00;
   int          seed = 32'h213b_1520, n_mismatch = 0, num_checks = 0;
   always #10 mclk = ~mclk;
   damlc_top uut (.mclk, .rst, .ce, .regWrite(wr), .regIndex(idx), .regWrData(wd), .regRdData(rd),
      .doublewordSel(dw), .countBy4(by4), .lineCmpBit8(1'b0), .lineCmpBit9(1'b0), .charClkTick(tk),
      .horizontalRetracePulse(hp), .frameStart(fs), .rowStart(rs), .displayActive(act), .rowScan(scan),
      .lineStartLoad(ls), .rowOffset(ro), .hRetraceIn(hi), .vRetraceIn(vi), .hRetraceOut(ho),
      .vRetraceOut(vo), .refreshMemoryAddressOut(ma), .vertCount(vc), .lineMatch(lm));
   damlc_mem_model mem (.mclk, .fetchEn(tk & ce), .addr(ma), .lastFetch(mf));
   // reference mux: shift first, then the row scan substitutions
   function automatic logic [15:0] mapA(input logic [7:0] md, input logic d, input logic [15:0] c);
      logic [15:0] s;
      s = d ? {c[13:0], c[13], c[12]} : (md[6] ? c : {c[14:0], md[5] ? c[15] : c[13]});
      if (!md[1]) s[14] = scan[1];
      if (!md[0] && act) s[13] = scan[0];
      return s;
   endfunction : mapA
   // inputs change 1 ns after the edge; retrace inputs are random every cycle
   task cyc(input int n = 1);
      repeat (n) begin
         @(posedge mclk);
         #1;
         cmp("hRetrace", 16'(hi & mx[7]), 16'(ho));
         cmp("vRetrace", 16'(vi & mx[7]), 16'(vo));
         {hi, vi} = 2'($random(seed));
      end
   endtask : cyc
   task cmp(input string nm, input logic [15:0] ex, input logic [15:0] got);
      num_checks++;
      if (ex !== got) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : cmp
   task wreg(input logic [7:0] i, input logic [7:0] d);
      wr = 1;
      idx = i;
      wd = d;
      if (i == 8'h17) mx = d & 8'hEF;
      cyc();
      wr = 0;
   endtask : wreg
   task frame(input logic [15:0] l);
      fs = 1;
      ls = l;
      cyc();
      fs = 0;
   endtask : frame
   task tick(input int n);
      tk = 1;
      cyc(n);
      tk = 0;
      cyc();
   endtask : tick
   task give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   // hang guard, far beyond the roughly 160 cycles the sequence needs
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      ro = 16'($random(seed));
      cyc(6);
      rst = 0;
      idx = 8'h17;
      #1 cmp("modeReset", 16'h0000, 16'(rd));
      idx = 8'h18;
      #1 cmp("cmpReset", 16'h00FF, 16'(rd));
      wreg(8'h20, 8'h55);
      cmp("unmapped", 16'h0000, 16'(rd));
      // random modes, wrap, doubleword, row scan and display state
      repeat (24) begin
         m = 8'($random(seed));
         {dw, act, scan} = 7'($random(seed));
         wreg(8'h17, m);
         cmp("modeRead", 16'(m & 8'hEF), 16'(rd));
         v = 16'($random(seed));
         frame(v);
         tick(1);
         e = mapA(m, dw, v);
         cmp("addr", e, ma);
         cmp("fetch", e, mf);
      end
      {dw, act, scan} = '0;
      // word mode with the wrap bit set, as software picks for the large memory
      wreg(8'h17, 8'hA3);
      frame(16'h8000);
      tick(1);
      cmp("wrap", 16'h0001, ma);
      // counter rate: every tick, every second, every fourth
      for (int k = 0; k < 3; k++) begin
         wreg(8'h17, k == 1 ? 8'hCB : 8'hC3);
         by4 = (k == 2);
         v = 16'($random(seed));
         frame(v);
         tick(4);
         tick(1);
         cmp("rate", v + (16'h0004 >> k), ma);
      end
      by4 = 0;
      // vertical rate, then split line compare with and without a match
      for (int k = 0; k < 2; k++) begin
         wreg(8'h17, k == 1 ? 8'hC7 : 8'hC3);
         wreg(8'h18, 8'h02);
         frame(16'h1234);
         hp = 1;
         cyc(4);
         hp = 0;
         cyc();
         cmp("vcount", 16'h0004 >> k, 16'(vc));
         cmp("match", 16'(k), 16'(lm));
         rs = 1;
         cyc();
         rs = 0;
         tick(1);
         cmp("split", k == 1 ? 16'h0000 : 16'h1234 + ro, ma);
      end
      // clock enable low freezes the address path
      ce = 0;
      frame(16'h0F0F);
      tick(1);
      cmp("freeze", 16'h0000, ma);
      ce = 1;
      give_verdict();
   end
endmodule : tb
bind damlc_top damlc_properties chk (.mclk, .rst, .ce, .regIndex, .regRdData, .lineCmpBit8, .lineCmpBit9,
   .charClkTick, .horizontalRetracePulse, .frameStart, .rowStart, .rowScan, .hRetraceIn, .vRetraceIn,
   .hRetraceOut, .vRetraceOut, .refreshMemoryAddressOut, .vertCount, .lineMatch);
